// file: magnetometer_register_bank.sv
// Register bank of a three-axis magnetometer behind a byte-level serial interface.
//
// Behaviour
// R1 - Continuous mode refreshes axis registers at rate.
// R2 - Output registers change only on newer sample.
// R3 - Axis samples: 16-bit signed, low byte even.
// R4 - Axis samples saturate instead of wrapping.
// R5 - Status register holds three read-only flags.
// R6 - Ready bit 0, overflow bit 1, skipped bit 2.
// R7 - Ready flag set when full sample loaded.
// R8 - Reading axis registers clears ready and skipped.
// R9 - Overflow set when any axis out of range.
// R10 - Overflow clears only on next in-range measurement.
// R11 - Skipped set when unread set gets replaced.
// R12 - Temperature: 16-bit signed at 07H and 08H.
// R13 - First control register field layout.
// R14 - Mode 00 standby, 01 continuous, others reserved.
// R15 - Standby after reset; mode changes any time.
// R16 - Update rate codes give 10 to 200 Hz.
// R17 - Range code 00 is 2G, 01 is 8G.
// R18 - Oversample codes give 512 down to 64.
// R19 - Second control: reset, wrap, interrupt disable bits.
// R20 - Interrupt pin shows new data unless disabled.
// R21 - Read pointer wraps 06H to 00H when enabled.
// R22 - Soft reset restores defaults, returns to standby.
// R23 - Host writes 01H into set/reset period.
// R24 - Pointer advances by one after each byte.
`timescale 1ns/1ps

module magnetometer_register_bank #(
    parameter int unsigned PERIOD_RATE0 = magnetometer_pkg::CLK_HZ / magnetometer_pkg::RATE0_HZ,
    parameter int unsigned PERIOD_RATE1 = magnetometer_pkg::CLK_HZ / magnetometer_pkg::RATE1_HZ,
    parameter int unsigned PERIOD_RATE2 = magnetometer_pkg::CLK_HZ / magnetometer_pkg::RATE2_HZ,
    parameter int unsigned PERIOD_RATE3 = magnetometer_pkg::CLK_HZ / magnetometer_pkg::RATE3_HZ
) (
    input  wire logic                          CLK_I,
    input  wire logic                          RESET_I,
    input  wire logic                          ADDR_SET_I,
    input  wire logic                          WRITE_I,
    input  wire logic [7:0]                    WDATA_I,
    input  wire logic                          READ_I,
    output logic      [7:0]                    RDATA_O,
    input  wire logic                          SAMPLE_VALID_I,
    input  wire magnetometer_pkg::raw_sample_t SAMPLE_I,
    output logic                               MEAS_REQ_O,
    output magnetometer_pkg::meas_config_t     CONFIG_O,
    output logic      [7:0]                    SETRESET_PERIOD_O,
    output logic                               INT_O
);

    // Saturate a raw axis value to the 16-bit output span.
    function automatic logic [15:0] clamp_axis(input logic signed [17:0] raw);
        if (raw > magnetometer_pkg::RAW_MAX) begin
            clamp_axis = magnetometer_pkg::SAMPLE_MAX;
        end else if (raw < magnetometer_pkg::RAW_MIN) begin
            clamp_axis = magnetometer_pkg::SAMPLE_MIN;
        end else begin
            clamp_axis = raw[15:0];
        end
    endfunction

    function automatic logic out_of_range(input logic signed [17:0] raw);
        out_of_range = (raw > magnetometer_pkg::RAW_MAX) || (raw < magnetometer_pkg::RAW_MIN);
    endfunction

    function automatic logic [22:0] rate_period(input logic [1:0] code);
        case (code)
            magnetometer_pkg::RATE_10HZ:  rate_period = PERIOD_RATE0[22:0];
            magnetometer_pkg::RATE_50HZ:  rate_period = PERIOD_RATE1[22:0];
            magnetometer_pkg::RATE_100HZ: rate_period = PERIOD_RATE2[22:0];
            default:                      rate_period = PERIOD_RATE3[22:0];
        endcase
    endfunction

    magnetometer_pkg::meas_config_t cfg_q;
    logic                           wrap_en_q;
    logic                           irq_dis_q;
    logic [7:0]                     sr_period_q;
    logic [15:0]                    x_q;
    logic [15:0]                    y_q;
    logic [15:0]                    z_q;
    logic [15:0]                    temp_q;
    logic                           ready_q;
    logic                           over_q;
    logic                           skip_q;
    logic                           unread_q;
    logic [7:0]                     ptr_q;
    logic [7:0]                     ptr_d;
    logic                           wrap_zone_q;
    logic [7:0]                     rdata_q;
    logic [7:0]                     rdata_d;
    logic [22:0]                    rate_cnt_q;
    logic                           req_q;
    logic [7:0]                     status_byte;
    logic [7:0]                     misc_byte;
    logic                           continuous;
    logic                           soft_rst;
    logic                           load;
    logic                           data_read;
    logic                           any_over;
    logic                           wr_meas;
    logic                           wr_misc;
    logic                           wr_period;
    logic                           do_read;

    // Reserved mode codes behave as standby, so no stray measurement starts.
    assign continuous = (cfg_q.mode == magnetometer_pkg::MODE_CONTINUOUS);           // R14
    assign wr_meas    = WRITE_I && !ADDR_SET_I && (ptr_q == magnetometer_pkg::ADDR_MEAS_CFG);
    assign wr_misc    = WRITE_I && !ADDR_SET_I && (ptr_q == magnetometer_pkg::ADDR_MISC_CTRL);
    assign wr_period  = WRITE_I && !ADDR_SET_I && (ptr_q == magnetometer_pkg::ADDR_SR_PERIOD);
    assign soft_rst   = wr_misc && WDATA_I[magnetometer_pkg::MISC_SRST_BIT];           // R22
    assign do_read    = READ_I && !ADDR_SET_I && !WRITE_I;
    assign data_read  = do_read && (ptr_q <= magnetometer_pkg::ADDR_Z_HIGH);            // R8
    assign load       = SAMPLE_VALID_I && continuous && !soft_rst;                       // R1
    assign any_over   = out_of_range(SAMPLE_I.x) || out_of_range(SAMPLE_I.y)
                        || out_of_range(SAMPLE_I.z);                                     // R9

    // Control registers; the soft reset bit is not stored and reads back zero.
    always_ff @(posedge CLK_I) begin
        if (RESET_I || soft_rst) begin                                                   // R15 R22
            cfg_q     <= magnetometer_pkg::MEAS_CFG_RESET;
            wrap_en_q <= 1'b0;
            irq_dis_q <= 1'b0;
        end else if (wr_meas) begin
            cfg_q <= WDATA_I;                                                            // R13
        end else if (wr_misc) begin
            wrap_en_q <= WDATA_I[magnetometer_pkg::MISC_WRAP_BIT];                       // R19
            irq_dis_q <= WDATA_I[magnetometer_pkg::MISC_IRQD_BIT];                       // R19
        end
    end

    // The period value is only handed to the set/reset driver; 01H is the host's job.
    always_ff @(posedge CLK_I) begin
        if (RESET_I || soft_rst) begin
            sr_period_q <= magnetometer_pkg::SR_PERIOD_RESET;
        end else if (wr_period) begin
            sr_period_q <= WDATA_I;                                                      // R23
        end
    end

    // Output data registers keep their value until a newer sample arrives.
    always_ff @(posedge CLK_I) begin
        if (RESET_I || soft_rst) begin
            x_q    <= 16'h0000;
            y_q    <= 16'h0000;
            z_q    <= 16'h0000;
            temp_q <= 16'h0000;
        end else if (load) begin                                                         // R2
            x_q    <= clamp_axis(SAMPLE_I.x);                                            // R3 R4
            y_q    <= clamp_axis(SAMPLE_I.y);                                            // R3 R4
            z_q    <= clamp_axis(SAMPLE_I.z);                                            // R3 R4
            temp_q <= SAMPLE_I.temperature;                                              // R12
        end
    end

    // A load in the same cycle as a clearing read wins, so no event is lost.
    always_ff @(posedge CLK_I) begin
        if (RESET_I || soft_rst) begin
            ready_q <= 1'b0;
        end else if (load) begin
            ready_q <= 1'b1;                                                             // R7
        end else if (data_read) begin
            ready_q <= 1'b0;                                                             // R8
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I || soft_rst) begin
            over_q <= 1'b0;
        end else if (load) begin
            over_q <= any_over;                                                          // R9 R10
        end
    end

    // The unread marker tracks whether any axis register of the current set was read.
    always_ff @(posedge CLK_I) begin
        if (RESET_I || soft_rst) begin
            unread_q <= 1'b0;
        end else if (load) begin
            unread_q <= 1'b1;
        end else if (data_read) begin
            unread_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I || soft_rst) begin
            skip_q <= 1'b0;
        end else if (load && unread_q) begin
            skip_q <= 1'b1;                                                              // R11
        end else if (data_read) begin
            skip_q <= 1'b0;                                                              // R8
        end
    end

    // Measurement request timer; held at zero outside continuous mode so that
    // the first request follows one cycle after entering continuous mode.
    always_ff @(posedge CLK_I) begin
        if (RESET_I || soft_rst || !continuous) begin
            rate_cnt_q <= '0;
            req_q      <= 1'b0;
        end else if (rate_cnt_q == '0) begin
            rate_cnt_q <= rate_period(cfg_q.update_rate_select) - 23'h000001;            // R16
            req_q      <= 1'b1;                                                          // R1
        end else begin
            rate_cnt_q <= rate_cnt_q - 23'h000001;
            req_q      <= 1'b0;
        end
    end

    assign status_byte = {5'h00, skip_q, over_q, ready_q};                               // R5 R6
    assign misc_byte   = {1'b0, wrap_en_q, 5'h00, irq_dis_q};                            // R19

    // Read multiplexer; reserved and unmapped addresses read as zero.
    always_comb begin
        case (ptr_q)
            magnetometer_pkg::ADDR_X_LOW:     rdata_d = x_q[7:0];
            magnetometer_pkg::ADDR_X_HIGH:    rdata_d = x_q[15:8];
            magnetometer_pkg::ADDR_Y_LOW:     rdata_d = y_q[7:0];
            magnetometer_pkg::ADDR_Y_HIGH:    rdata_d = y_q[15:8];
            magnetometer_pkg::ADDR_Z_LOW:     rdata_d = z_q[7:0];
            magnetometer_pkg::ADDR_Z_HIGH:    rdata_d = z_q[15:8];
            magnetometer_pkg::ADDR_STATUS:    rdata_d = status_byte;
            magnetometer_pkg::ADDR_TEMP_LOW:  rdata_d = temp_q[7:0];
            magnetometer_pkg::ADDR_TEMP_HIGH: rdata_d = temp_q[15:8];
            magnetometer_pkg::ADDR_MEAS_CFG:  rdata_d = cfg_q;
            magnetometer_pkg::ADDR_MISC_CTRL: rdata_d = misc_byte;
            magnetometer_pkg::ADDR_SR_PERIOD: rdata_d = sr_period_q;
            default:                          rdata_d = magnetometer_pkg::READ_ZERO;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            rdata_q <= magnetometer_pkg::READ_ZERO;
        end else if (do_read) begin
            rdata_q <= rdata_d;
        end
    end

    // Wrapping depends on where the read started, which is the address last set.
    always_comb begin
        ptr_d = ptr_q;
        if (ADDR_SET_I) begin
            ptr_d = WDATA_I;
        end else if (WRITE_I) begin
            ptr_d = ptr_q + 8'h01;                                                       // R24
        end else if (READ_I) begin
            if (wrap_en_q && wrap_zone_q && (ptr_q == magnetometer_pkg::ADDR_STATUS)) begin
                ptr_d = magnetometer_pkg::ADDR_FIRST;                                    // R21
            end else begin
                ptr_d = ptr_q + 8'h01;                                                   // R24
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            ptr_q       <= magnetometer_pkg::ADDR_FIRST;
            wrap_zone_q <= 1'b0;
        end else begin
            ptr_q <= ptr_d;
            if (ADDR_SET_I) begin
                wrap_zone_q <= (WDATA_I <= magnetometer_pkg::ADDR_STATUS);               // R21
            end
        end
    end

    assign RDATA_O           = rdata_q;
    assign MEAS_REQ_O        = req_q;
    assign CONFIG_O          = cfg_q;                                                    // R17 R18
    assign SETRESET_PERIOD_O = sr_period_q;
    assign INT_O             = ready_q && !irq_dis_q;                                    // R20

    // Checks kept beside the logic they guard.
    sequence load_s;
        load;
    endsequence

    sequence axis_read_s;
        data_read && !load && !soft_rst;
    endsequence

    property ready_after_load_p;
        @(posedge CLK_I) disable iff (RESET_I) load_s |=> ready_q;
    endproperty

    ready_set_a: assert property (ready_after_load_p) // R7
        else $error("Ready flag not set after a sample load.");

    read_clear_a: assert property ( // R8
        @(posedge CLK_I) disable iff (RESET_I) axis_read_s |=> !ready_q && !skip_q)
        else $error("Axis read did not clear ready and skipped flags.");

    over_track_a: assert property ( // R9
        @(posedge CLK_I) disable iff (RESET_I)
        load_s |=> (over_q == $past(any_over)))
        else $error("Overflow flag does not follow the latest measurement.");

    over_hold_a: assert property ( // R10
        @(posedge CLK_I) disable iff (RESET_I)
        !load && !soft_rst |=> $stable(over_q))
        else $error("Overflow flag changed without a measurement.");

    clamp_high_a: assert property ( // R4
        @(posedge CLK_I) disable iff (RESET_I)
        load && (SAMPLE_I.x > magnetometer_pkg::RAW_MAX) |=> (x_q == magnetometer_pkg::SAMPLE_MAX))
        else $error("Positive overrange sample was not saturated.");

    clamp_low_a: assert property ( // R4
        @(posedge CLK_I) disable iff (RESET_I)
        load && (SAMPLE_I.z < magnetometer_pkg::RAW_MIN) |=> (z_q == magnetometer_pkg::SAMPLE_MIN))
        else $error("Negative overrange sample was not saturated.");

    data_hold_a: assert property ( // R2
        @(posedge CLK_I) disable iff (RESET_I)
        !load && !soft_rst |=> $stable(x_q) && $stable(y_q) && $stable(z_q) && $stable(temp_q))
        else $error("Output data changed without a new sample.");

    skip_set_a: assert property ( // R11
        @(posedge CLK_I) disable iff (RESET_I)
        load_s ##1 (!data_read && !soft_rst)[*4] ##1 load_s |=> skip_q)
        else $error("Replaced unread sample set did not raise skipped flag.");

    soft_reset_a: assert property ( // R22
        @(posedge CLK_I) disable iff (RESET_I)
        soft_rst |=> (cfg_q.mode == magnetometer_pkg::MODE_STANDBY) && !wrap_en_q
                     && !ready_q && (sr_period_q == magnetometer_pkg::SR_PERIOD_RESET))
        else $error("Soft reset did not restore defaults.");

    standby_quiet_a: assert property ( // R15
        @(posedge CLK_I) disable iff (RESET_I)
        !continuous |=> !MEAS_REQ_O)
        else $error("Measurement requested outside continuous mode.");

    int_pin_a: assert property ( // R20
        @(posedge CLK_I) disable iff (RESET_I)
        load && !irq_dis_q && !wr_misc |=> INT_O)
        else $error("Interrupt pin did not follow new data.");

    ptr_wrap_a: assert property ( // R21
        @(posedge CLK_I) disable iff (RESET_I)
        do_read && wrap_en_q && wrap_zone_q && (ptr_q == magnetometer_pkg::ADDR_STATUS)
        |=> (ptr_q == magnetometer_pkg::ADDR_FIRST))
        else $error("Read pointer did not wrap to the first register.");

    ptr_step_a: assert property ( // R24
        @(posedge CLK_I) disable iff (RESET_I)
        READ_I && !ADDR_SET_I && !WRITE_I && (ptr_q != magnetometer_pkg::ADDR_STATUS)
        |=> (ptr_q == $past(ptr_q) + 8'h01))
        else $error("Read pointer did not advance by one.");

    read_data_a: assert property ( // R3
        @(posedge CLK_I) disable iff (RESET_I)
        do_read && (ptr_q == magnetometer_pkg::ADDR_Y_HIGH) |=> (RDATA_O == y_q[15:8]))
        else $error("High byte of an axis sample read from the wrong place.");

    status_ro_a: assert property ( // R5
        @(posedge CLK_I) disable iff (RESET_I)
        do_read && (ptr_q == magnetometer_pkg::ADDR_STATUS) |=> (RDATA_O[7:3] == 5'h00))
        else $error("Reserved status bits read nonzero.");

    temp_read_a: assert property ( // R12
        @(posedge CLK_I) disable iff (RESET_I)
        do_read && (ptr_q == magnetometer_pkg::ADDR_TEMP_HIGH) |=> (RDATA_O == temp_q[15:8]))
        else $error("High byte of the temperature read from the wrong place.");

    srst_read_a: assert property ( // R19
        @(posedge CLK_I) disable iff (RESET_I)
        do_read && (ptr_q == magnetometer_pkg::ADDR_MISC_CTRL)
        |=> (RDATA_O[magnetometer_pkg::MISC_SRST_BIT] == 1'b0))
        else $error("Soft reset bit did not read back as zero.");

    rate_first_a: assert property ( // R1
        @(posedge CLK_I) disable iff (RESET_I)
        !continuous ##1 (continuous && !soft_rst) |=> MEAS_REQ_O)
        else $error("No measurement request after entering continuous mode.");

endmodule // magnetometer_register_bank

// file: magnetometer_pkg.sv
// Constants, register map and carrier types of the magnetometer register bank.
package magnetometer_pkg;

    // Register addresses as seen by the serial interface pointer.
    localparam logic [7:0] ADDR_X_LOW     = 8'h00;
    localparam logic [7:0] ADDR_X_HIGH    = 8'h01;
    localparam logic [7:0] ADDR_Y_LOW     = 8'h02;
    localparam logic [7:0] ADDR_Y_HIGH    = 8'h03;
    localparam logic [7:0] ADDR_Z_LOW     = 8'h04;
    localparam logic [7:0] ADDR_Z_HIGH    = 8'h05;
    localparam logic [7:0] ADDR_STATUS    = 8'h06;
    localparam logic [7:0] ADDR_TEMP_LOW  = 8'h07;
    localparam logic [7:0] ADDR_TEMP_HIGH = 8'h08;
    localparam logic [7:0] ADDR_MEAS_CFG  = 8'h09;
    localparam logic [7:0] ADDR_MISC_CTRL = 8'h0A;
    localparam logic [7:0] ADDR_SR_PERIOD = 8'h0B;
    localparam logic [7:0] ADDR_FIRST     = 8'h00;

    // Bit positions inside the status and second control registers.
    localparam int unsigned STAT_READY_BIT = 0;
    localparam int unsigned STAT_OVER_BIT  = 1;
    localparam int unsigned STAT_SKIP_BIT  = 2;
    localparam int unsigned MISC_SRST_BIT  = 7;
    localparam int unsigned MISC_WRAP_BIT  = 6;
    localparam int unsigned MISC_IRQD_BIT  = 0;

    // Reset values of the writable registers; zero byte for read data and unmapped reads.
    localparam logic [7:0] MEAS_CFG_RESET  = 8'h00;
    localparam logic [7:0] SR_PERIOD_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO       = 8'h00;

    // Field encodings.
    localparam logic [1:0] MODE_STANDBY    = 2'h0;
    localparam logic [1:0] MODE_CONTINUOUS = 2'h1;
    localparam logic [1:0] RATE_10HZ       = 2'h0;
    localparam logic [1:0] RATE_50HZ       = 2'h1;
    localparam logic [1:0] RATE_100HZ      = 2'h2;
    localparam logic [1:0] RATE_200HZ      = 2'h3;
    localparam logic [1:0] RANGE_2G        = 2'h0;
    localparam logic [1:0] RANGE_8G        = 2'h1;
    localparam logic [1:0] OSR_512         = 2'h0;
    localparam logic [1:0] OSR_256         = 2'h1;
    localparam logic [1:0] OSR_128         = 2'h2;
    localparam logic [1:0] OSR_64          = 2'h3;

    // Timing: clock rate and update rates in hertz, and the rate counter width.
    localparam int unsigned CLK_HZ      = 50_000_000;
    localparam int unsigned RATE0_HZ    = 10;
    localparam int unsigned RATE1_HZ    = 50;
    localparam int unsigned RATE2_HZ    = 100;
    localparam int unsigned RATE3_HZ    = 200;
    localparam int unsigned CNT_W       = 23;

    // Sample widths and saturation limits.
    localparam int unsigned RAW_W = 18;
    localparam logic signed [RAW_W-1:0] RAW_MAX = 18'sh07FFF;
    localparam logic signed [RAW_W-1:0] RAW_MIN = -18'sh08000;
    localparam logic [15:0] SAMPLE_MAX = 16'h7FFF;
    localparam logic [15:0] SAMPLE_MIN = 16'h8000;

    // Layout matches the first control register, bit 7 down to bit 0.
    typedef struct packed {
        logic [1:0] oversample_ratio;
        logic [1:0] field_range;
        logic [1:0] update_rate_select;
        logic [1:0] mode;
    } meas_config_t;

    // One raw measurement from the front end, before saturation.
    typedef struct packed {
        logic signed [RAW_W-1:0] x;
        logic signed [RAW_W-1:0] y;
        logic signed [RAW_W-1:0] z;
        logic        [15:0]      temperature;
    } raw_sample_t;

endpackage

// file: frontend_model.sv
// Behavioural front end that answers each measurement request with one raw sample.
`timescale 1ns/1ps
module frontend_model #(
    parameter int unsigned LATENCY = 3
) (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          req_i,
    input  wire magnetometer_pkg::raw_sample_t smp_i,
    output logic                               valid_o,
    output magnetometer_pkg::raw_sample_t      data_o
);
    logic [LATENCY-1:0] dly_q;
    // Between samples the data carries the inverse, so a capture at the wrong edge shows up.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dly_q <= '0;
            valid_o <= 1'b0;
        end else begin
            dly_q <= {dly_q[LATENCY-2:0], req_i};
            valid_o <= dly_q[LATENCY-1];
        end
        data_o <= dly_q[LATENCY-1] ? smp_i : ~smp_i;
    end
endmodule // frontend_model

// file: magnetometer_register_bank_tb.sv
// Self-checking testbench of the magnetometer register bank.
`timescale 1ns/1ps
module magnetometer_register_bank_tb;
    logic                           clk = 1'b0;
    logic                           rst = 1'b1;
    logic                           aset = 1'b0;
    logic                           wr_en = 1'b0;
    logic                           rd_en = 1'b0;
    logic [7:0]                     wdata = 8'h00;
    logic [7:0]                     rdata;
    logic [7:0]                     setp;
    logic [7:0]                     v;
    logic                           sv;
    logic                           mreq;
    logic                           irq;
    magnetometer_pkg::raw_sample_t  smp_in;
    magnetometer_pkg::raw_sample_t  smp = '0;
    magnetometer_pkg::meas_config_t cfg;
    logic [7:0]                     exp_a [9] = '{8'hFF, 8'h7F, 8'h00, 8'h80, 8'h34, 8'h12,
                                                  8'h02, 8'hCD, 8'hAB};
    int                             errors = 0;
    int                             n_checks = 0;
    always #10 clk = ~clk;
    magnetometer_register_bank #(.PERIOD_RATE0(40), .PERIOD_RATE1(20), .PERIOD_RATE2(10),
        .PERIOD_RATE3(5)) dut_u (.CLK_I(clk), .RESET_I(rst), .ADDR_SET_I(aset),
        .WRITE_I(wr_en), .WDATA_I(wdata), .READ_I(rd_en), .RDATA_O(rdata),
        .SAMPLE_VALID_I(sv), .SAMPLE_I(smp_in), .MEAS_REQ_O(mreq), .CONFIG_O(cfg),
        .SETRESET_PERIOD_O(setp), .INT_O(irq));
    frontend_model #(.LATENCY(5)) fe_u (.clk_i(clk), .rst_i(rst), .req_i(mreq),
        .smp_i(smp), .valid_o(sv), .data_o(smp_in));
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One access cycle; read data is taken once the answering edge has landed.
    task automatic step(input logic s, input logic w, input logic r, input logic [7:0] d);
        @(posedge clk);
        aset <= s;
        wr_en <= w;
        rd_en <= r;
        wdata <= d;
        @(posedge clk);
        aset <= 1'b0;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        step(1'b1, 1'b0, 1'b0, a);
        step(1'b0, 1'b1, 1'b0, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
        step(1'b1, 1'b0, 1'b0, a);
        step(1'b0, 1'b0, 1'b1, 8'h00);
        chk(nm, e, v);
    endtask
    task automatic wait_smp;
        int i;
        for (i = 0; i < 200 && sv !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk("sample arrival", 8'h01, {7'h00, sv});
        @(posedge clk);
        #1;
    endtask
    // The first pulse after the write is reloaded with the new rate, so the next gap is clean.
    task automatic rate_chk(input logic [7:0] c, input logic [7:0] e);
        int n;
        wr(8'h09, c);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (mreq !== 1'b1 && n < 100);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (mreq !== 1'b1 && n < 100);
        chk("request period", e, 8'(n));
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rchk(8'h09, 8'h00, "mode after reset");
        rchk(8'h06, 8'h00, "status after reset");
        wr(8'h0B, 8'h01);
        chk("period out", 8'h01, setp);
        smp = {18'sh09C40, -18'sh09C40, 18'sh01234, 16'hABCD};
        wr(8'h09, 8'hD1);
        chk("config out", 8'hD1, cfg);
        wait_smp();
        chk("irq pin", 8'h01, {7'h00, irq});
        rchk(8'h06, 8'h03, "ready and overflow");
        step(1'b1, 1'b0, 1'b0, 8'h00);
        foreach (exp_a[k]) begin
            step(1'b0, 1'b0, 1'b1, 8'h00);
            chk("burst byte", exp_a[k], v);
        end
        smp = {18'sh00055, -18'sh00001, 18'sh07FFF, 16'h0000};
        wait_smp();
        rchk(8'h06, 8'h01, "overflow cleared");
        wait_smp();
        rchk(8'h06, 8'h05, "skipped set");
        $display("test sampling done");
        rate_chk(8'h0D, 8'h05);
        rate_chk(8'h05, 8'h14);
        wr(8'h0A, 8'h01);
        chk("irq disabled", 8'h00, {7'h00, irq});
        wr(8'h0A, 8'h00);
        chk("irq enabled", 8'h01, {7'h00, irq});
        wr(8'h09, 8'h00);
        wr(8'h0A, 8'h40);
        rchk(8'h05, 8'h7F, "z high");
        step(1'b0, 1'b0, 1'b1, 8'h00);
        step(1'b0, 1'b0, 1'b1, 8'h00);
        chk("wrapped byte", 8'h55, v);
        rchk(8'h0A, 8'h40, "misc control");
        $display("test pointer done");
        wr(8'h0A, 8'h81);
        chk("config after soft reset", 8'h00, cfg);
        rchk(8'h0B, 8'h00, "period after soft reset");
        wr(8'h00, 8'hFF);
        rchk(8'h00, 8'h00, "read-only axis");
        rchk(8'h0C, 8'h00, "unmapped");
        $display("test reset done");
        stop_test();
    end
    initial begin
        #50000;
        errors++;
        stop_test();
    end
endmodule // magnetometer_register_bank_tb
